/* design/dbu_pkg.sv */
package dbu_pkg;
    // Register numbers of the debug register space
    localparam logic [7:0] DBU_REG_CAUSE = 8'h15;
    localparam logic [7:0] DBU_REG_EVENT_DATA = 8'h16;
    localparam logic [7:0] DBU_REG_STOP_VECTOR = 8'h18;
    localparam logic [7:0] DBU_REG_SCRATCH = 8'h20;
    localparam logic [7:0] DBU_REG_IBRK_ADDR = 8'h30;
    localparam logic [7:0] DBU_REG_IBRK_CTRL = 8'h40;
    localparam logic [7:0] DBU_REG_DW_LOW = 8'h50;
    localparam logic [7:0] DBU_REG_DW_HIGH = 8'h60;
    localparam logic [7:0] DBU_REG_DW_CTRL = 8'h70;
    localparam logic [7:0] DBU_REG_RW_MASK = 8'h80;
    localparam logic [7:0] DBU_REG_RW_VALUE = 8'h90;
    localparam logic [7:0] DBU_REG_RW_CTRL = 8'h9C;
    // Tile configuration space number of the scratch words
    localparam logic [7:0] DBU_CFG_SCRATCH = 8'h20;
    // Field positions
    localparam int DBU_CAUSE_LSB = 0;
    localparam int DBU_INDEX_LSB = 16;
    localparam int DBU_THREAD_LSB = 8;
    localparam int DBU_CTRL_ARM_BIT = 0;
    localparam int DBU_CTRL_COND_BIT = 1;
    localparam int DBU_CTRL_LOAD_BIT = 2;
    localparam int DBU_CTRL_THREADS_LSB = 16;
    // Write masks of the narrow registers
    localparam logic [31:0] DBU_CAUSE_WMASK = 32'h0003FF07;
    localparam logic [31:0] DBU_STOP_WMASK = 32'h000000FF;
    localparam logic [31:0] DBU_IBRK_CTRL_WMASK = 32'h00FF0003;
    localparam logic [31:0] DBU_DW_CTRL_WMASK = 32'h00FF0007;
    localparam logic [31:0] DBU_RW_CTRL_WMASK = 32'h00FF0003;
    localparam logic [31:0] DBU_RESET_WORD = 32'h00000000;
    typedef enum logic [2:0] {
        DBU_CAUSE_NONE = 3'h0,
        DBU_CAUSE_HOST = 3'h1,
        DBU_CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2,
        DBU_CAUSE_IBRK = 3'h3,
        DBU_CAUSE_DWATCH = 3'h4,
        DBU_CAUSE_RWATCH = 3'h5
    } dbu_cause_t;
endpackage

/* design/dbu_match.sv */
`timescale 1ns/1ps
`default_nettype none
// One trigger slot: instruction, data and resource comparisons
module dbu_match
    import dbu_pkg::*;
(
    // Slot configuration
    input wire logic [31:0] i_ib_addr,
    input wire logic [31:0] i_ib_ctrl,
    input wire logic [31:0] i_dw_low,
    input wire logic [31:0] i_dw_high,
    input wire logic [31:0] i_dw_ctrl,
    input wire logic [31:0] i_rw_mask,
    input wire logic [31:0] i_rw_value,
    input wire logic [31:0] i_rw_ctrl,
    // Pipeline view
    input wire logic [7:0] i_thread_bit,
    input wire logic i_pc_valid,
    input wire logic [31:0] i_pc,
    input wire logic i_mem_valid,
    input wire logic i_mem_store,
    input wire logic [31:0] i_mem_addr,
    input wire logic i_res_valid,
    input wire logic [31:0] i_res_id,
    // Hits
    output logic o_ib_hit,
    output logic o_dw_hit,
    output logic o_rw_hit
);
    function automatic logic armed(input logic [31:0] ctrl, input logic [7:0] tbit);
        armed = ctrl[DBU_CTRL_ARM_BIT]
            && ((ctrl[DBU_CTRL_THREADS_LSB +: 8] & tbit) != 8'h00);
    endfunction

    logic cond_a;
    logic cond_b;
    logic pc_eq;
    logic access_ok;

    always_comb
    begin
        pc_eq = (i_pc == i_ib_addr);
        o_ib_hit = i_pc_valid && armed(i_ib_ctrl, i_thread_bit)
            && (i_ib_ctrl[DBU_CTRL_COND_BIT] ? !pc_eq : pc_eq);
        cond_a = (i_mem_addr >= i_dw_low);
        cond_b = (i_mem_addr <= i_dw_high);
        access_ok = i_mem_store || i_dw_ctrl[DBU_CTRL_LOAD_BIT];
        o_dw_hit = i_mem_valid && access_ok && armed(i_dw_ctrl, i_thread_bit)
            && (i_dw_ctrl[DBU_CTRL_COND_BIT] ? (cond_a || cond_b)
                                              : (cond_a && cond_b));
        // Condition select has no second comparison defined; it is stored only
        o_rw_hit = i_res_valid && armed(i_rw_ctrl, i_thread_bit)
            && ((i_res_id & i_rw_mask) == i_rw_value);
    end
endmodule
`default_nettype wire

/* design/dbu_breakpoint_unit.sv */
// Operation
// - Cause code records debug interrupt origin
// - Trigger index, zero for host/call, lowest wins
// - Thread number stored, zero for host
// - Event data: address or resource identifier
// - Stop vector halts threads outside debug
// - Eight scratch words shared by two paths
// - Four instruction breakpoints with address registers
// - Arm bit and thread mask, reset clear
// - Bit 1 selects equal or differ
// - Condition A: address at/above low bound
// - Condition B: address at/below high bound
// - Bit 1 combines A AND B / OR
// - Stores always; loads only when enabled
// - Watch arm and thread mask, reset zero
// - Four resource mask registers
// - Four resource value registers
// - Resource control: arm, condition, threads
`timescale 1ns/1ps
`default_nettype none
module dbu_breakpoint_unit
    import dbu_pkg::*;
#(
    parameter int NUM_SLOTS = 4,
    parameter int NUM_SCRATCH = 8
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Debug register port (core side)
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_num,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    // Tile configuration port for scratch words
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_num,
    input wire logic [31:0] i_cfg_wdata,
    output logic [31:0] o_cfg_rdata,
    // Pipeline
    input wire logic [2:0] i_thread,
    input wire logic i_pc_valid,
    input wire logic [31:0] i_pc,
    input wire logic i_mem_valid,
    input wire logic i_mem_store,
    input wire logic [31:0] i_mem_addr,
    input wire logic i_res_valid,
    input wire logic [31:0] i_res_id,
    input wire logic i_debug_call_instruction,
    input wire logic i_debug_return,
    // Host request and debug status
    input wire logic i_host_req,
    output logic o_debug_take,
    output logic o_in_debug,
    output logic [7:0] o_thread_stop
);
    initial
    begin
        if (NUM_SLOTS != 4 || NUM_SCRATCH != 8)
            $error("dbu_breakpoint_unit supports four slots and eight scratch words");
    end

    logic [31:0] cause;
    logic [31:0] event_data;
    logic [7:0] stop_vector;
    logic [7:0] run_halt;
    logic in_debug;
    logic [31:0] scratch [NUM_SCRATCH];
    logic [31:0] ib_addr [NUM_SLOTS];
    logic [31:0] ib_ctrl [NUM_SLOTS];
    logic [31:0] dw_low [NUM_SLOTS];
    logic [31:0] dw_high [NUM_SLOTS];
    logic [31:0] dw_ctrl [NUM_SLOTS];
    logic [31:0] rw_mask [NUM_SLOTS];
    logic [31:0] rw_value [NUM_SLOTS];
    logic [31:0] rw_ctrl [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] ib_hit;
    logic [NUM_SLOTS-1:0] dw_hit;
    logic [NUM_SLOTS-1:0] rw_hit;
    logic [7:0] thread_bit;
    logic [2:0] host_sync;

    // Host request comes from the debug-access clock; three stages
    logic host_req;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            host_sync <= 3'h0;
        else
            host_sync <= {host_sync[1:0], i_host_req};
    end
    logic host_level;
    logic next_host_level;
    always_comb
    begin
        next_host_level = host_level;
        if (host_sync[1] == host_sync[2])
            next_host_level = host_sync[2];
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            host_level <= 1'b0;
        else
            host_level <= next_host_level;
    end
    assign host_req = host_level;

    assign thread_bit = 8'h01 << i_thread;

    for (genvar g = 0; g < NUM_SLOTS; g++)
    begin : g_slot
        dbu_match u_match (
            .i_ib_addr(ib_addr[g]),
            .i_ib_ctrl(ib_ctrl[g]),
            .i_dw_low(dw_low[g]),
            .i_dw_high(dw_high[g]),
            .i_dw_ctrl(dw_ctrl[g]),
            .i_rw_mask(rw_mask[g]),
            .i_rw_value(rw_value[g]),
            .i_rw_ctrl(rw_ctrl[g]),
            .i_thread_bit(thread_bit),
            .i_pc_valid(i_pc_valid),
            .i_pc(i_pc),
            .i_mem_valid(i_mem_valid),
            .i_mem_store(i_mem_store),
            .i_mem_addr(i_mem_addr),
            .i_res_valid(i_res_valid),
            .i_res_id(i_res_id),
            .o_ib_hit(ib_hit[g]),
            .o_dw_hit(dw_hit[g]),
            .o_rw_hit(rw_hit[g])
        );
    end

    function automatic logic [1:0] lowest(input logic [3:0] v);
        lowest = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    endfunction

    // Entry decision; hits are ignored while already in debug mode
    dbu_cause_t take_cause;
    logic [1:0] take_index;
    logic [31:0] take_data;
    always_comb
    begin
        take_cause = DBU_CAUSE_NONE;
        take_index = 2'd0;
        take_data = event_data;
        if (!in_debug)
        begin
            if (host_req)
                take_cause = DBU_CAUSE_HOST;
            else if (i_debug_call_instruction)
                take_cause = DBU_CAUSE_DEBUG_CALL_INSTRUCTION;
            else if (ib_hit != '0)
            begin
                take_cause = DBU_CAUSE_IBRK;
                take_index = lowest(ib_hit);
            end
            else if (dw_hit != '0)
            begin
                take_cause = DBU_CAUSE_DWATCH;
                take_index = lowest(dw_hit);
                take_data = i_mem_addr;
            end
            else if (rw_hit != '0)
            begin
                take_cause = DBU_CAUSE_RWATCH;
                take_index = lowest(rw_hit);
                take_data = i_res_id;
            end
        end
    end
    assign o_debug_take = (take_cause != DBU_CAUSE_NONE);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // Register state
    logic [31:0] next_cause;
    logic [31:0] next_event_data;
    logic [7:0] next_stop_vector;
    logic [7:0] next_run_halt;
    logic next_in_debug;
    logic [31:0] next_scratch [NUM_SCRATCH];
    logic [31:0] next_ib_addr [NUM_SLOTS];
    logic [31:0] next_ib_ctrl [NUM_SLOTS];
    logic [31:0] next_dw_low [NUM_SLOTS];
    logic [31:0] next_dw_high [NUM_SLOTS];
    logic [31:0] next_dw_ctrl [NUM_SLOTS];
    logic [31:0] next_rw_mask [NUM_SLOTS];
    logic [31:0] next_rw_value [NUM_SLOTS];
    logic [31:0] next_rw_ctrl [NUM_SLOTS];
    always_comb
    begin
        next_cause = cause;
        next_event_data = event_data;
        next_stop_vector = stop_vector;
        next_run_halt = run_halt;
        next_in_debug = in_debug;
        next_scratch = scratch;
        next_ib_addr = ib_addr;
        next_ib_ctrl = ib_ctrl;
        next_dw_low = dw_low;
        next_dw_high = dw_high;
        next_dw_ctrl = dw_ctrl;
        next_rw_mask = rw_mask;
        next_rw_value = rw_value;
        next_rw_ctrl = rw_ctrl;
        if (i_reg_wr)
        begin
            if (i_reg_num == DBU_REG_CAUSE)
                next_cause = merge(cause, i_reg_wdata, DBU_CAUSE_WMASK);
            else if (i_reg_num == DBU_REG_EVENT_DATA)
                next_event_data = i_reg_wdata;
            else if (i_reg_num == DBU_REG_STOP_VECTOR)
                next_stop_vector = i_reg_wdata[7:0];
            else if (i_reg_num[7:3] == DBU_REG_SCRATCH[7:3])
                next_scratch[i_reg_num[2:0]] = i_reg_wdata;
            else if (i_reg_num[7:2] == DBU_REG_IBRK_ADDR[7:2])
                next_ib_addr[i_reg_num[1:0]] = i_reg_wdata;
            else if (i_reg_num[7:2] == DBU_REG_IBRK_CTRL[7:2])
                next_ib_ctrl[i_reg_num[1:0]] = i_reg_wdata & DBU_IBRK_CTRL_WMASK;
            else if (i_reg_num[7:2] == DBU_REG_DW_LOW[7:2])
                next_dw_low[i_reg_num[1:0]] = i_reg_wdata;
            else if (i_reg_num[7:2] == DBU_REG_DW_HIGH[7:2])
                next_dw_high[i_reg_num[1:0]] = i_reg_wdata;
            else if (i_reg_num[7:2] == DBU_REG_DW_CTRL[7:2])
                next_dw_ctrl[i_reg_num[1:0]] = i_reg_wdata & DBU_DW_CTRL_WMASK;
            else if (i_reg_num[7:2] == DBU_REG_RW_MASK[7:2])
                next_rw_mask[i_reg_num[1:0]] = i_reg_wdata;
            else if (i_reg_num[7:2] == DBU_REG_RW_VALUE[7:2])
                next_rw_value[i_reg_num[1:0]] = i_reg_wdata;
            else if (i_reg_num[7:2] == DBU_REG_RW_CTRL[7:2])
                next_rw_ctrl[i_reg_num[1:0]] = i_reg_wdata & DBU_RW_CTRL_WMASK;
        end
        // Config path written second: on a clash with the core port it wins
        if (i_cfg_wr && i_cfg_num[7:3] == DBU_CFG_SCRATCH[7:3])
            next_scratch[i_cfg_num[2:0]] = i_cfg_wdata;
        if (o_debug_take)
        begin
            next_cause = DBU_RESET_WORD;
            next_cause[DBU_CAUSE_LSB +: 3] = take_cause;
            next_cause[DBU_INDEX_LSB +: 2] = take_index;
            if (take_cause != DBU_CAUSE_HOST)
                next_cause[DBU_THREAD_LSB +: 8] = {5'h00, i_thread};
            next_event_data = take_data;
            next_in_debug = 1'b1;
        end
        else if (in_debug && i_debug_return)
        begin
            next_in_debug = 1'b0;
            next_run_halt = next_stop_vector;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cause <= DBU_RESET_WORD;
            event_data <= DBU_RESET_WORD;
            stop_vector <= 8'h00;
            run_halt <= 8'h00;
            in_debug <= 1'b0;
            for (int i = 0; i < NUM_SCRATCH; i++)
                scratch[i] <= DBU_RESET_WORD;
            for (int i = 0; i < NUM_SLOTS; i++)
            begin
                ib_addr[i] <= DBU_RESET_WORD;
                ib_ctrl[i] <= DBU_RESET_WORD;
                dw_low[i] <= DBU_RESET_WORD;
                dw_high[i] <= DBU_RESET_WORD;
                dw_ctrl[i] <= DBU_RESET_WORD;
                rw_mask[i] <= DBU_RESET_WORD;
                rw_value[i] <= DBU_RESET_WORD;
                rw_ctrl[i] <= DBU_RESET_WORD;
            end
        end
        else
        begin
            cause <= next_cause;
            event_data <= next_event_data;
            stop_vector <= next_stop_vector;
            run_halt <= next_run_halt;
            in_debug <= next_in_debug;
            scratch <= next_scratch;
            ib_addr <= next_ib_addr;
            ib_ctrl <= next_ib_ctrl;
            dw_low <= next_dw_low;
            dw_high <= next_dw_high;
            dw_ctrl <= next_dw_ctrl;
            rw_mask <= next_rw_mask;
            rw_value <= next_rw_value;
            rw_ctrl <= next_rw_ctrl;
        end
    end

    // Read paths; unknown numbers read zero
    always_comb
    begin
        o_reg_rdata = DBU_RESET_WORD;
        if (i_reg_num == DBU_REG_CAUSE)
            o_reg_rdata = cause;
        else if (i_reg_num == DBU_REG_EVENT_DATA)
            o_reg_rdata = event_data;
        else if (i_reg_num == DBU_REG_STOP_VECTOR)
            o_reg_rdata = {24'h000000, stop_vector};
        else if (i_reg_num[7:3] == DBU_REG_SCRATCH[7:3])
            o_reg_rdata = scratch[i_reg_num[2:0]];
        else if (i_reg_num[7:2] == DBU_REG_IBRK_ADDR[7:2])
            o_reg_rdata = ib_addr[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_IBRK_CTRL[7:2])
            o_reg_rdata = ib_ctrl[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_DW_LOW[7:2])
            o_reg_rdata = dw_low[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_DW_HIGH[7:2])
            o_reg_rdata = dw_high[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_DW_CTRL[7:2])
            o_reg_rdata = dw_ctrl[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_RW_MASK[7:2])
            o_reg_rdata = rw_mask[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_RW_VALUE[7:2])
            o_reg_rdata = rw_value[i_reg_num[1:0]];
        else if (i_reg_num[7:2] == DBU_REG_RW_CTRL[7:2])
            o_reg_rdata = rw_ctrl[i_reg_num[1:0]];
        o_cfg_rdata = DBU_RESET_WORD;
        if (i_cfg_num[7:3] == DBU_CFG_SCRATCH[7:3])
            o_cfg_rdata = scratch[i_cfg_num[2:0]];
    end

    assign o_in_debug = in_debug;
    // Stopped threads only matter outside debug mode
    assign o_thread_stop = in_debug ? 8'h00 : run_halt;

    cover property (@(posedge i_clk) disable iff (i_rst) take_cause == DBU_CAUSE_IBRK);
    cover property (@(posedge i_clk) disable iff (i_rst) take_cause == DBU_CAUSE_DWATCH);
    cover property (@(posedge i_clk) disable iff (i_rst) take_cause == DBU_CAUSE_RWATCH);
    cover property (@(posedge i_clk) disable iff (i_rst) in_debug && i_debug_return);

    cause_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_debug_take |=> cause[2:0] == $past(take_cause))
        else $error("cause code not captured");
    index_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_debug_take && take_cause == DBU_CAUSE_IBRK && ib_hit[0]) |=> cause[17:16] == 2'd0)
        else $error("lowest index not chosen");
    host_thread_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_debug_take && take_cause == DBU_CAUSE_HOST) |=> cause[17:8] == 10'h000)
        else $error("host entry must store zero thread and index");
    data_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_debug_take && take_cause == DBU_CAUSE_DWATCH) |=> event_data == $past(i_mem_addr))
        else $error("event data not the access address");
    stop_return_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_debug && i_debug_return && !o_debug_take && !i_reg_wr)
        |=> o_thread_stop == $past(stop_vector))
        else $error("stop vector not applied on return");
    scratch_share_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cfg_wr && i_cfg_num[7:3] == DBU_CFG_SCRATCH[7:3])
        |=> scratch[$past(i_cfg_num[2:0])] == $past(i_cfg_wdata))
        else $error("config scratch write lost");
    no_hit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_pc_valid && !i_mem_valid && !i_res_valid && !i_debug_call_instruction && !host_req)
        |-> !o_debug_take)
        else $error("entry without any cause");
    in_debug_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_debug_take |=> o_in_debug && o_thread_stop == 8'h00)
        else $error("debug mode not entered");
endmodule
`default_nettype wire

/* testbench/dbu_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Debugger side: holds the request level until the core reports debug mode
module dbu_host_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Test control and core status
    input wire logic i_raise,
    input wire logic i_in_debug,
    // Request to the tile
    output logic o_host_req
);
    // Dropped on entry, else a level request would re-enter after return
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_host_req <= 1'b0;
        else if (i_in_debug)
            o_host_req <= 1'b0;
        else if (i_raise)
            o_host_req <= 1'b1;
    end
endmodule
`default_nettype wire

/* testbench/dbu_breakpoint_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dbu_breakpoint_unit_tb;
    import dbu_pkg::*;
    typedef struct {logic [7:0] wn; logic [31:0] wd; int k; logic st; logic [31:0] a;
        logic tk; logic [31:0] cs;} dbu_row_t;
    logic i_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_cfg_wr = 1'b0;
    logic [7:0] i_reg_num = 8'h00, i_cfg_num = 8'h00, o_thread_stop;
    logic [31:0] i_reg_wdata = 32'h0, i_cfg_wdata = 32'h0, o_reg_rdata, o_cfg_rdata;
    logic [2:0] i_thread = 3'h0;
    logic [31:0] i_pc = 32'h0, i_mem_addr = 32'h0, i_res_id = 32'h0;
    logic i_pc_valid = 1'b0, i_mem_valid = 1'b0, i_mem_store = 1'b0, i_res_valid = 1'b0;
    logic i_debug_call_instruction = 1'b0, i_debug_return = 1'b0, raise = 1'b0, host_req;
    logic o_debug_take, o_in_debug;
    int mismatches = 0, num_checks = 0, cycles = 0;
    dbu_row_t rows [11];
    dbu_breakpoint_unit dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
        .i_reg_num(i_reg_num), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_cfg_wr(i_cfg_wr), .i_cfg_num(i_cfg_num), .i_cfg_wdata(i_cfg_wdata),
        .o_cfg_rdata(o_cfg_rdata), .i_thread(i_thread), .i_pc_valid(i_pc_valid), .i_pc(i_pc),
        .i_mem_valid(i_mem_valid), .i_mem_store(i_mem_store), .i_mem_addr(i_mem_addr),
        .i_res_valid(i_res_valid), .i_res_id(i_res_id), .i_debug_call_instruction(i_debug_call_instruction),
        .i_debug_return(i_debug_return), .i_host_req(host_req), .o_debug_take(o_debug_take),
        .o_in_debug(o_in_debug), .o_thread_stop(o_thread_stop));
    dbu_host_model host_u (.i_clk(i_clk), .i_rst(i_rst), .i_raise(raise),
        .i_in_debug(o_in_debug), .o_host_req(host_req));
    initial
    begin
        forever #10 i_clk = ~i_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Ceiling well above the fewer than two hundred cycles the sequence needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] n, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_num <= n;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] n, input logic [31:0] e);
        @(posedge i_clk);
        i_reg_num <= n;
        #1 chk(o_reg_rdata, e, "register read");
    endtask
    task automatic ret(input logic [7:0] stop);
        @(posedge i_clk);
        i_debug_return <= 1'b1;
        @(posedge i_clk);
        i_debug_return <= 1'b0;
        #1 chk({31'h0, o_in_debug}, 32'h0, "debug exit");
        chk({24'h0, o_thread_stop}, {24'h0, stop}, "stop vector after return");
    endtask
    initial
    begin
        rows = '{
            '{8'h41, 32'h00010001, 0, 1'b0, 32'h00000100, 1'b1, 32'h00010003},
            '{8'h00, 32'h00000000, 0, 1'b0, 32'h00000104, 1'b0, 32'h0},
            '{8'h41, 32'h00010003, 0, 1'b0, 32'h00000104, 1'b1, 32'h00010003},
            '{8'h70, 32'h00010001, 1, 1'b1, 32'h00001800, 1'b1, 32'h00000004},
            '{8'h00, 32'h00000000, 1, 1'b0, 32'h00001800, 1'b0, 32'h0},
            '{8'h70, 32'h00010005, 1, 1'b0, 32'h00001800, 1'b1, 32'h00000004},
            '{8'h00, 32'h00000000, 1, 1'b1, 32'h00002000, 1'b0, 32'h0},
            '{8'h70, 32'h00010007, 1, 1'b1, 32'h00002000, 1'b1, 32'h00000004},
            '{8'h70, 32'h00020001, 1, 1'b1, 32'h00001800, 1'b0, 32'h0},
            '{8'h70, 32'h00000000, 2, 1'b0, 32'h000012AB, 1'b1, 32'h00020005},
            '{8'h00, 32'h00000000, 2, 1'b0, 32'h000013AB, 1'b0, 32'h0}};
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(DBU_REG_IBRK_CTRL, 32'h0);
        rd(DBU_REG_DW_CTRL, 32'h0);
        rd(DBU_REG_RW_CTRL, 32'h0);
        rd(8'h01, 32'h0);
        wr(DBU_REG_RW_CTRL, 32'hFFFFFFFF);
        rd(DBU_REG_RW_CTRL, 32'h00FF0003);
        wr(DBU_REG_RW_CTRL, 32'h0);
        $display("test reset and access done");
        @(posedge i_clk);
        i_cfg_wr <= 1'b1;
        i_cfg_num <= 8'h23;
        i_cfg_wdata <= 32'hA5A5C3C3;
        @(posedge i_clk);
        i_cfg_wr <= 1'b0;
        rd(8'h23, 32'hA5A5C3C3);
        wr(8'h25, 32'h5A5A3C3C);
        i_cfg_num <= 8'h25;
        #1 chk(o_cfg_rdata, 32'h5A5A3C3C, "scratch via config");
        $display("test scratch done");
        wr(8'h50, 32'h00001000);
        wr(8'h60, 32'h00001FFF);
        wr(8'h31, 32'h00000100);
        wr(8'h82, 32'h0000FF00);
        wr(8'h92, 32'h00001200);
        wr(8'h9E, 32'h00010001);
        foreach (rows[i])
        begin
            if (rows[i].wn != 8'h00)
                wr(rows[i].wn, rows[i].wd);
            @(posedge i_clk);
            i_pc_valid <= (rows[i].k == 0);
            i_mem_valid <= (rows[i].k == 1);
            i_res_valid <= (rows[i].k == 2);
            i_pc <= rows[i].a;
            i_mem_addr <= rows[i].a;
            i_res_id <= rows[i].a;
            i_mem_store <= rows[i].st;
            #1 chk(32'(o_debug_take), 32'(rows[i].tk), "hit");
            @(posedge i_clk);
            i_pc_valid <= 1'b0;
            i_mem_valid <= 1'b0;
            i_res_valid <= 1'b0;
            if (rows[i].tk)
            begin
                rd(DBU_REG_CAUSE, rows[i].cs);
                if (rows[i].k != 0)
                    rd(DBU_REG_EVENT_DATA, rows[i].a);
                ret(8'h00);
            end
            $display("test row %0d done", i);
        end
        wr(8'h30, 32'h00000100);
        wr(8'h40, 32'h00010001);
        wr(8'h41, 32'h00010001);
        @(posedge i_clk);
        i_pc_valid <= 1'b1;
        i_pc <= 32'h00000100;
        @(posedge i_clk);
        i_pc_valid <= 1'b0;
        rd(DBU_REG_CAUSE, 32'h00000003);
        ret(8'h00);
        $display("test lowest index done");
        wr(DBU_REG_STOP_VECTOR, 32'h00000024);
        @(posedge i_clk);
        i_debug_call_instruction <= 1'b1;
        i_thread <= 3'h5;
        #1 chk({31'h0, o_debug_take}, 32'h1, "debug call entry");
        @(posedge i_clk);
        i_debug_call_instruction <= 1'b0;
        #1 chk({24'h0, o_thread_stop}, 32'h0, "stop vector in debug");
        rd(DBU_REG_CAUSE, 32'h00000502);
        ret(8'h24);
        wr(DBU_REG_STOP_VECTOR, 32'h0);
        $display("test debug call and stop done");
        @(posedge i_clk);
        raise <= 1'b1;
        @(posedge i_clk);
        raise <= 1'b0;
        repeat (10)
        begin
            if (o_in_debug !== 1'b1)
                @(posedge i_clk);
            #1;
        end
        #1 chk({31'h0, o_in_debug}, 32'h1, "host entry");
        rd(DBU_REG_CAUSE, 32'h00000001);
        // Let the dropped request drain through the synchroniser first
        repeat (6) @(posedge i_clk);
        ret(8'h00);
        repeat (4) @(posedge i_clk);
        #1 chk({31'h0, o_in_debug}, 32'h0, "re-entry after host drop");
        $display("test host request done");
        rd(8'h41, 32'h00010001);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(8'h41, 32'h0);
        rd(8'h9E, 32'h0);
        rd(DBU_REG_CAUSE, 32'h0);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
`default_nettype wire
